// ### shared/rcs_defines.vh
// Constants for the reset cause status capture block
`ifndef RCS_DEFINES_VH
`define RCS_DEFINES_VH

// ************************************************
// Register offsets (byte addresses)
// ************************************************
`define RCS_AW              8
`define RCS_OFS_CAUSE       8'h00
`define RCS_OFS_IRQ_STATUS  8'h04
`define RCS_OFS_IRQ_MASK    8'h08

// ************************************************
// Flag layout
// ************************************************
`define RCS_FLAG_W          8
`define RCS_BIT_POWER_ON    7
`define RCS_BIT_EXT_PIN     6
`define RCS_BIT_WATCHDOG    5
`define RCS_BIT_BAD_OPCODE  4
`define RCS_BIT_BAD_ADDR    3
`define RCS_BIT_WAKEUP      2
`define RCS_BIT_LOW_SUPPLY  1
`define RCS_BIT_SPARE       0
`define RCS_BIT_DEBUG_EVT   0

// ************************************************
// Reset and fixed values
// ************************************************
`define RCS_POWER_ON_FLAGS  8'h82
`define RCS_LOW_SUPPLY_FLAGS 8'h82
`define RCS_CLEAR_FLAGS     8'h00
`define RCS_MASK_RESET      8'h00
`define RCS_STATUS_RESET    8'h00
`define RCS_DATA_PAD        24'h000000
`define RCS_DATA_ZERO       32'h00000000
`define RCS_SYNC_RESET      2'h1

// ************************************************
// Power modes
// ************************************************
`define RCS_MODE_W          3
`define RCS_MODE_RUN        3'h0
`define RCS_MODE_WAIT       3'h1
`define RCS_MODE_STOP4      3'h2
`define RCS_MODE_STOP3      3'h3
`define RCS_MODE_STOP2      3'h4
`define RCS_MODE_STOP1      3'h5

// ************************************************
// Timing
// ************************************************
`define RCS_CLK_PERIOD_NS   10
`define RCS_HOLD_NS         1000
`define RCS_HOLD_CYCLES     ((`RCS_HOLD_NS + `RCS_CLK_PERIOD_NS - 1) / `RCS_CLK_PERIOD_NS)

`endif

// ### logic/rcs_cause_merge.v
// Next reset cause flags from the active sources and the held flags
`timescale 1ns/1ps
`include "rcs_defines.vh"

module rcs_cause_merge #(
    parameter FLAG_W = `RCS_FLAG_W
) (
    input  wire [FLAG_W-1:0] prevFlags,
    input  wire [FLAG_W-1:0] srcFlags,
    input  wire              lowSupplyTrip,
    input  wire              debugForce,
    input  wire              holding,
    output reg  [FLAG_W-1:0] nextFlags
);

    wire [FLAG_W-1:0] merged;

    // ************************************************
    // Per-flag accumulation
    // ************************************************
    genvar i;
    generate
        for (i = 0; i < FLAG_W; i = i + 1) begin : gFlag
            if (i == `RCS_BIT_SPARE) begin : gSpare
                assign merged[i] = 1'b0;
            end else begin : gSrc
                assign merged[i] = (holding & prevFlags[i]) | srcFlags[i];
            end
        end
    endgenerate

    // ************************************************
    // Priority between reset kinds
    // ************************************************
    always @* begin
        nextFlags = merged;
        if (lowSupplyTrip) begin
            nextFlags = `RCS_LOW_SUPPLY_FLAGS;
        end else if (holding && prevFlags[`RCS_BIT_LOW_SUPPLY]) begin
            // Low supply outranks later sources
            nextFlags = prevFlags;
        end else if (debugForce && !holding) begin
            nextFlags = `RCS_CLEAR_FLAGS;
        end
    end

endmodule // rcs_cause_merge

// ### logic/rcs_reset_cause.v
// Reset cause capture, reset sequencing and APB register slave
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "rcs_defines.vh"

module rcs_reset_cause #(
    parameter ADDR_W      = `RCS_AW,
    parameter HOLD_CYCLES = `RCS_HOLD_CYCLES,
    parameter CNT_W       = 16
) (
    input  wire                   clk,
    input  wire                   rst_n,
    input  wire                   psel,
    input  wire                   penable,
    input  wire                   pwrite,
    input  wire [ADDR_W-1:0]      paddr,
    input  wire [31:0]            pwdata,
    output reg  [31:0]            prdata,
    output wire                   pready,
    output reg                    pslverr,
    input  wire                   extResetPin_n,
    input  wire                   supplyBelowTrip,
    input  wire                   lowSupplyResetEnable,
    input  wire                   lowSupplyStopEnable,
    input  wire                   watchdogTimeout,
    input  wire                   watchdogEnableOption,
    input  wire                   unimplementedOpcode,
    input  wire                   stopInstruction,
    input  wire                   stopAllowOption,
    input  wire                   enterBackgroundInstruction,
    input  wire                   backgroundModeEnable,
    input  wire                   dataAccessBadAddr,
    input  wire                   fetchBadAddr,
    input  wire                   wakeupResetReq,
    input  wire [`RCS_MODE_W-1:0] powerMode,
    input  wire                   debugForceResetBit,
    output reg                    mcuReset,
    output reg                    watchdogRestart,
    output reg  [7:0]             resetCauseStatus,
    output wire                   irq
);

    // ************************************************
    // Sequencer states
    // ************************************************
    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_HOLD  = 2'h1;
    localparam [1:0] ST_DRAIN = 2'h2;

    localparam [CNT_W-1:0] HOLD_LOAD = HOLD_CYCLES - 1;
    localparam [CNT_W-1:0] CNT_ZERO  = {CNT_W{1'b0}};
    localparam [CNT_W-1:0] CNT_ONE   = {{(CNT_W-1){1'b0}}, 1'b1};

    reg  [1:0]       sync1_q;
    reg  [1:0]       sync2_q;
    reg  [1:0]       state_q;
    reg  [1:0]       state_d;
    reg  [CNT_W-1:0] cnt_q;
    reg  [CNT_W-1:0] cnt_d;
    reg  [7:0]       flags_d;
    reg  [7:0]       status_q;
    reg  [7:0]       status_d;
    reg  [7:0]       mask_q;
    reg  [7:0]       mask_d;
    reg  [7:0]       setBits;
    reg  [31:0]      prdata_d;
    reg              pslverr_d;

    wire             extPinLow;
    wire             supplyLow;
    wire             lowSupplyTrip;
    wire             watchdogSrc;
    wire             badOpcodeSrc;
    wire             badAddrSrc;
    wire             deepStop;
    wire             wakeupSrc;
    wire [7:0]       srcFlags;
    wire             anyCause;
    wire             holding;
    wire             entry;
    wire [7:0]       nextFlags;
    wire             setup;
    wire             access;
    wire             hitCause;
    wire             hitStatus;
    wire             hitMask;

    // ************************************************
    // Pin synchronisers
    // ************************************************
    // Both inputs are asynchronous to clk; two stages each
    always @(posedge clk) begin
        if (!rst_n) begin
            sync1_q <= `RCS_SYNC_RESET;
            sync2_q <= `RCS_SYNC_RESET;
        end else begin
            sync1_q <= {supplyBelowTrip, extResetPin_n};
            sync2_q <= sync1_q;
        end
    end

    assign extPinLow = ~sync2_q[0];
    assign supplyLow = sync2_q[1];

    // ************************************************
    // Reset source qualification
    // ************************************************
    // both enables needed
    assign lowSupplyTrip = supplyLow & lowSupplyResetEnable & lowSupplyStopEnable;

    assign watchdogSrc = watchdogTimeout & watchdogEnableOption;

    assign badOpcodeSrc = unimplementedOpcode
                        | (stopInstruction & ~stopAllowOption)
                        | (enterBackgroundInstruction & ~backgroundModeEnable);

    assign badAddrSrc = dataAccessBadAddr | fetchBadAddr;

    assign deepStop  = (powerMode == `RCS_MODE_STOP2) | (powerMode == `RCS_MODE_STOP1);
    assign wakeupSrc = wakeupResetReq & ~deepStop;

    assign srcFlags = {1'b0, extPinLow, watchdogSrc, badOpcodeSrc,
                       badAddrSrc, wakeupSrc, 1'b0, 1'b0};

    // deep stop wakeup still resets, its flag stays clear
    assign anyCause = lowSupplyTrip | debugForceResetBit | wakeupResetReq | (|srcFlags);
    assign holding  = (state_q != ST_IDLE);
    assign entry    = (state_q == ST_IDLE) & anyCause;

    // ************************************************
    // Flag merge
    // ************************************************
    rcs_cause_merge #(
        .FLAG_W        (`RCS_FLAG_W)
    ) uMerge (
        .prevFlags     (resetCauseStatus),
        .srcFlags      (srcFlags),
        .lowSupplyTrip (lowSupplyTrip),
        .debugForce    (debugForceResetBit),
        .holding       (holding),
        .nextFlags     (nextFlags)
    );

    // ************************************************
    // Reset sequencer
    // ************************************************
    // Reset is held a minimum time, then until every cause is gone
    always @* begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            ST_IDLE: begin
                if (anyCause) begin
                    state_d = ST_HOLD;
                    cnt_d   = HOLD_LOAD;
                end
            end
            ST_HOLD: begin
                if (cnt_q == CNT_ZERO) begin
                    state_d = ST_DRAIN;
                end else begin
                    cnt_d = cnt_q - CNT_ONE;
                end
            end
            ST_DRAIN: begin
                if (!anyCause) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
                cnt_d   = CNT_ZERO;
            end
        endcase
    end

    // ************************************************
    // Flag capture
    // ************************************************
    always @* begin
        flags_d = resetCauseStatus;
        if (entry || holding) begin
            flags_d = nextFlags;
        end
        flags_d[`RCS_BIT_SPARE] = 1'b0;
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            state_q          <= ST_IDLE;
            cnt_q            <= CNT_ZERO;
            mcuReset         <= 1'b0;
            resetCauseStatus <= `RCS_POWER_ON_FLAGS;
        end else begin
            state_q          <= state_d;
            cnt_q            <= cnt_d;
            mcuReset         <= (state_d != ST_IDLE);
            resetCauseStatus <= flags_d;
        end
    end

    // ************************************************
    // APB decode
    // ************************************************
    // Zero wait states; read data is staged in the setup cycle
    assign pready    = 1'b1;
    assign setup     = psel & ~penable;
    assign access    = psel & penable;
    assign hitCause  = (paddr == `RCS_OFS_CAUSE);
    assign hitStatus = (paddr == `RCS_OFS_IRQ_STATUS);
    assign hitMask   = (paddr == `RCS_OFS_IRQ_MASK);

    always @* begin
        prdata_d  = prdata;
        pslverr_d = pslverr;
        if (setup) begin
            pslverr_d = ~(hitCause | hitStatus | hitMask);
            if (pwrite) begin
                prdata_d = `RCS_DATA_ZERO;
            end else if (hitCause) begin
                prdata_d = {`RCS_DATA_PAD, resetCauseStatus};
            end else if (hitStatus) begin
                prdata_d = {`RCS_DATA_PAD, status_q};
            end else if (hitMask) begin
                prdata_d = {`RCS_DATA_PAD, mask_q};
            end else begin
                prdata_d = `RCS_DATA_ZERO;
            end
        end
    end

    // ************************************************
    // Interrupt status and mask
    // ************************************************
    always @* begin
        setBits = `RCS_CLEAR_FLAGS;
        if (entry) begin
            setBits = nextFlags;
            setBits[`RCS_BIT_DEBUG_EVT] = debugForceResetBit & ~lowSupplyTrip;
        end else if (holding) begin
            setBits = nextFlags & ~resetCauseStatus;
        end
    end

    always @* begin
        status_d = status_q;
        mask_d   = mask_q;
        if (access && !pwrite && hitStatus) begin
            // Only bits actually returned are cleared
            status_d = status_q & ~prdata[7:0];
        end
        // Set wins over read clear
        status_d = status_d | setBits;
        if (access && pwrite && hitMask) begin
            mask_d = pwdata[7:0];
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            status_q        <= `RCS_STATUS_RESET;
            mask_q          <= `RCS_MASK_RESET;
            prdata          <= `RCS_DATA_ZERO;
            pslverr         <= 1'b0;
            watchdogRestart <= 1'b0;
        end else begin
            status_q        <= status_d;
            mask_q          <= mask_d;
            prdata          <= prdata_d;
            pslverr         <= pslverr_d;
            watchdogRestart <= access & pwrite & hitCause;
        end
    end

    assign irq = |(status_q & mask_q);

endmodule // rcs_reset_cause

// ### testbench/rcs_reset_cause_monitor.sv
// Assertion checker for the reset cause capture block
`timescale 1ns/1ps
`include "rcs_defines.vh"
module rcs_reset_cause_monitor #(
    parameter ADDR_W      = 8,
    parameter HOLD_CYCLES = 2,
    parameter CNT_W       = 16
) (
    input logic                   clk,
    input logic                   rst_n,
    input logic                   psel,
    input logic                   penable,
    input logic                   pwrite,
    input logic [ADDR_W-1:0]      paddr,
    input logic [31:0]            pwdata,
    input logic [31:0]            prdata,
    input logic                   pready,
    input logic                   pslverr,
    input logic                   extResetPin_n,
    input logic                   supplyBelowTrip,
    input logic                   lowSupplyResetEnable,
    input logic                   lowSupplyStopEnable,
    input logic                   watchdogTimeout,
    input logic                   watchdogEnableOption,
    input logic                   unimplementedOpcode,
    input logic                   stopInstruction,
    input logic                   stopAllowOption,
    input logic                   enterBackgroundInstruction,
    input logic                   backgroundModeEnable,
    input logic                   dataAccessBadAddr,
    input logic                   fetchBadAddr,
    input logic                   wakeupResetReq,
    input logic [`RCS_MODE_W-1:0] powerMode,
    input logic                   debugForceResetBit,
    input logic                   mcuReset,
    input logic                   watchdogRestart,
    input logic [7:0]             resetCauseStatus,
    input logic                   irq
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire wrCause = psel && penable && pwrite && paddr == 8'h00;
    // Supply trip arrives late through its synchroniser, so demand it quiet
    sequence s_calm;
        !supplyBelowTrip[*3] ##0 !mcuReset;
    endsequence
    sequence s_lowTrip;
        (lowSupplyResetEnable && lowSupplyStopEnable && supplyBelowTrip)[*3];
    endsequence
    property p_bit0; resetCauseStatus[0] == 1'b0; endproperty
    property p_por; $rose(rst_n) |-> resetCauseStatus == 8'h82 && !mcuReset; endproperty
    property p_hold; !$past(mcuReset) && !mcuReset |-> $stable(resetCauseStatus); endproperty
    property p_restart; wrCause |=> watchdogRestart; endproperty
    property p_onlyRestart; watchdogRestart |-> $past(wrCause); endproperty
    property p_dog;
        s_calm ##0 (watchdogTimeout && watchdogEnableOption && !debugForceResetBit)
            |=> mcuReset && resetCauseStatus[5];
    endproperty
    property p_opc;
        s_calm ##0 (unimplementedOpcode && !debugForceResetBit) |=> resetCauseStatus[4];
    endproperty
    property p_addr;
        s_calm ##0 ((dataAccessBadAddr || fetchBadAddr) && !debugForceResetBit)
            |=> resetCauseStatus[3];
    endproperty
    property p_wake;
        s_calm ##0 (wakeupResetReq && !debugForceResetBit)
            |=> resetCauseStatus[2] == (powerMode < `RCS_MODE_STOP2);
    endproperty
    property p_debug; s_calm ##0 debugForceResetBit |=> resetCauseStatus == 8'h00; endproperty
    property p_low; s_lowTrip |=> resetCauseStatus == 8'h82; endproperty
    property p_mask;
        psel && penable && pwrite && paddr == 8'h08 && pwdata[7:0] == 8'h00 |=> !irq;
    endproperty
    a_bit0: assert property (p_bit0) else $error("spare flag bit set");
    a_por: assert property (p_por) else $error("wrong flags after reset");
    a_hold: assert property (p_hold) else $error("flags moved while idle");
    a_restart: assert property (p_restart) else $error("no watchdog restart");
    a_onlyRestart: assert property (p_onlyRestart) else $error("stray restart");
    a_dog: assert property (p_dog) else $error("watchdog cause lost");
    a_opc: assert property (p_opc) else $error("opcode cause lost");
    a_addr: assert property (p_addr) else $error("address cause lost");
    a_wake: assert property (p_wake) else $error("wakeup flag wrong");
    a_debug: assert property (p_debug) else $error("debug reset set flags");
    a_low: assert property (p_low) else $error("low supply pattern wrong");
    a_mask: assert property (p_mask) else $error("masked interrupt seen");
endmodule // rcs_reset_cause_monitor

bind rcs_reset_cause rcs_reset_cause_monitor #(
    .ADDR_W(ADDR_W), .HOLD_CYCLES(HOLD_CYCLES), .CNT_W(CNT_W)
) i_rcs_reset_cause_monitor (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extResetPin_n(extResetPin_n), .supplyBelowTrip(supplyBelowTrip),
    .lowSupplyResetEnable(lowSupplyResetEnable), .lowSupplyStopEnable(lowSupplyStopEnable),
    .watchdogTimeout(watchdogTimeout), .watchdogEnableOption(watchdogEnableOption),
    .unimplementedOpcode(unimplementedOpcode), .stopInstruction(stopInstruction),
    .stopAllowOption(stopAllowOption), .backgroundModeEnable(backgroundModeEnable),
    .enterBackgroundInstruction(enterBackgroundInstruction), .fetchBadAddr(fetchBadAddr),
    .dataAccessBadAddr(dataAccessBadAddr), .wakeupResetReq(wakeupResetReq),
    .powerMode(powerMode), .debugForceResetBit(debugForceResetBit), .mcuReset(mcuReset),
    .watchdogRestart(watchdogRestart), .resetCauseStatus(resetCauseStatus), .irq(irq)
);

// ### testbench/test_reset_cause_status_capture.sv
// Self-checking bench for the reset cause capture block
`timescale 1ns/1ps
`include "rcs_defines.vh"
module test_reset_cause_status_capture;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [14:0] src = 15'h0000;
    logic [2:0]  powerMode = 3'h0;
    logic [31:0] prdata, rd, seed;
    logic [7:0]  resetCauseStatus, prev;
    logic        pready, pslverr, mcuReset, watchdogRestart, irq, er;
    int          badCount = 0, totalChecks = 0, cyc = 0;
    // Source bits: 0 dog, 1 dog on, 2 opcode, 3 stop, 4 stop ok, 5 enter_background_instruction, 6 enter_background_instruction ok,
    // 7 data addr, 8 fetch addr, 9 wakeup, 10 debug, 11 trip, 12/13 enables, 14 pin
    logic [14:0] cases [14] = '{15'h0003, 15'h0008, 15'h0001, 15'h0080, 15'h0018,
        15'h0060, 15'h0020, 15'h0100, 15'h0004, 15'h4000, 15'h1800, 15'h0400,
        15'h3800, 15'h0000};

    rcs_reset_cause #(.HOLD_CYCLES(2)) i_rcs_reset_cause (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .extResetPin_n(~src[14]), .supplyBelowTrip(src[11]),
        .lowSupplyResetEnable(src[12]), .lowSupplyStopEnable(src[13]),
        .watchdogTimeout(src[0]), .watchdogEnableOption(src[1]),
        .unimplementedOpcode(src[2]), .stopInstruction(src[3]), .stopAllowOption(src[4]),
        .enterBackgroundInstruction(src[5]), .backgroundModeEnable(src[6]),
        .dataAccessBadAddr(src[7]), .fetchBadAddr(src[8]), .wakeupResetReq(src[9]),
        .powerMode(powerMode), .debugForceResetBit(src[10]), .mcuReset(mcuReset),
        .watchdogRestart(watchdogRestart), .resetCauseStatus(resetCauseStatus), .irq(irq)
    );

    // ****************************************
    // Helpers
    // ****************************************
    always #5 clk = ~clk;

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            badCount++;
            finalReport();
        end
    end

    task automatic finalReport();
        $display("checks %0d mismatches %0d", totalChecks, badCount);
        if (badCount == 0 && totalChecks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            badCount++;
            $display("BAD %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    // Low supply beats everything, debug clears, no cause keeps old flags
    function automatic logic [7:0] expF(input logic [14:0] s, input logic [2:0] m,
                                        input logic [7:0] p);
        logic [7:0] e;
        e = {1'b0, s[14], s[0] & s[1], s[2] | (s[3] & ~s[4]) | (s[5] & ~s[6]),
             s[7] | s[8], s[9] & (m < 3'h4), 2'b00};
        if (s[11] & s[12] & s[13]) e = 8'h82;
        else if (s[10]) e = 8'h00;
        else if (e == 8'h00 && !s[9]) e = p;
        return e;
    endfunction

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Sources held three cycles so the synchronised pins are caught too
    task automatic runCase(input logic [14:0] s, input logic [2:0] m);
        int n;
        n = 0;
        prev = expF(s, m, prev);
        @(posedge clk);
        src <= s;
        powerMode <= m;
        repeat (3) @(posedge clk);
        src <= s & 15'h3052;
        do begin
            @(negedge clk);
            n++;
        end while (mcuReset !== 1'b0 && n < 60);
        chk(n < 60, 1'b1);
        chk(resetCauseStatus, prev);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        seed = 32'h24;
        prev = 8'h82;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h82);
        apb(1'b1, 8'h00, 32'hFFFFFFFF);
        @(negedge clk);
        chk(watchdogRestart, 1'b1);
        @(negedge clk);
        chk({watchdogRestart, resetCauseStatus}, 9'h082);
        apb(1'b0, 8'h0C, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, 8'h08, 32'hFFFFFF20);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h20);
        apb(1'b0, 8'h04, 32'h0);
        foreach (cases[i]) runCase(cases[i], 3'h0);
        chk(irq, 1'b1);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd & 32'h20, 32'h20);
        @(negedge clk);
        chk(irq, 1'b0);
        runCase(15'h0080, 3'h0);
        chk(irq, 1'b0);
        apb(1'b1, 8'h08, 32'h08);
        @(negedge clk);
        chk(irq, 1'b1);
        for (int m = 0; m < 6; m++) runCase(15'h0200, m[2:0]);
        for (int k = 0; k < 40; k++) begin
            seed = xs(seed);
            runCase(seed[14:0] & 15'h3BFF, seed[18:16] % 3'h6);
            apb(1'b1, 8'h00, seed);
            @(negedge clk);
            chk(resetCauseStatus, prev);
        end
        apb(1'b1, 8'h08, 32'h0);
        @(negedge clk);
        chk(irq, 1'b0);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk({irq, resetCauseStatus}, 9'h082);
        finalReport();
    end
endmodule // test_reset_cause_status_capture
